// ---- hw/ufc_flow.sv ----
// flow-control handshake logic for the standard and fast serial ports
`timescale 1ns/1ps
`include "ufc_defines.svh"

// =====================================================================
// transmit fifo
module ufc_fifo
   import ufc_pkg::*;
#(
   parameter int WIDTH = `UFC_DATA_W,
   parameter int DEPTH = `UFC_FIFO_DEPTH
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic push;
   logic pop;
   // pointer step with wrap at any depth
   function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
      if (p == AW'(DEPTH - 1))
         step = '0;
      else
         step = p + 1'b1;
   endfunction
   // handshake terms
   assign in_ready = (count != (AW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem[rd_ptr];
   // storage write
   always_ff @(posedge clk)
   begin
      if (push)
         mem[wr_ptr] <= in_data;
   end
   // pointers and fill count
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end
      else
      begin
         if (push)
            wr_ptr <= step(wr_ptr);
         if (pop)
            rd_ptr <= step(rd_ptr);
         if (push && !pop)
            count <= count + 1'b1;
         else if (pop && !push)
            count <= count - 1'b1;
      end
   end
endmodule // ufc_fifo

// =====================================================================
// one serial port: transmit gating and receive-register handshake
module ufc_port
   import ufc_pkg::*;
#(
   parameter int BIT_CYCLES = `UFC_BIT_CYCLES,
   parameter int DEPTH = `UFC_FIFO_DEPTH
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic flow_en,
   input wire ufc_char_s tx_in,
   output logic tx_ready,
   input wire logic cts_in,
   output logic serial_out,
   output logic tx_busy,
   input wire ufc_char_s rx_in,
   input wire logic rx_read,
   output ufc_char_s rx_out,
   output logic rtr_out,
   output logic rtr_oe
);
   localparam int BCW = $clog2(BIT_CYCLES + 1);
   ufc_char_s fifo_out;
   ufc_char_s pending;
   ufc_tx_state_e state;
   ufc_tx_state_e next_state;
   logic fifo_pop;
   logic cts_meta;
   logic cts_sync;
   logic may_start;
   logic bit_end;
   logic [BCW-1:0] bit_cnt;
   logic [2:0] bit_idx;
   ufc_char_t shift;

   // =====================================================================
   // transmit side
   ufc_fifo #(
      .WIDTH(`UFC_DATA_W),
      .DEPTH(DEPTH)
   ) u_fifo (
      .clk(clk),
      .rst(rst),
      .in_valid(tx_in.valid),
      .in_ready(tx_ready),
      .in_data(tx_in.data),
      .out_valid(fifo_out.valid),
      .out_ready(fifo_pop),
      .out_data(fifo_out.data)
   );
   // refill the pending register only when it is empty
   assign fifo_pop = !pending.valid;
   // two-stage synchroniser for the clear-to-send pin
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         cts_meta <= 1'b0;
         cts_sync <= 1'b0;
      end
      else
      begin
         cts_meta <= cts_in;
         cts_sync <= cts_meta;
      end
   end
   // cts only matters with flow control on
   assign may_start = !flow_en || cts_sync;
   // pending character, held while cts is off
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         pending <= '0;
      else if (!pending.valid)
         pending <= fifo_out;
      else if (state == UFC_IDLE && may_start)
         pending.valid <= 1'b0;
   end
   assign bit_end = (bit_cnt == BCW'(BIT_CYCLES - 1));
   // frame sequencer; cts looked at in idle only
   always_comb
   begin
      next_state = state;
      case (state)
         UFC_IDLE:
            if (pending.valid && may_start)
               next_state = UFC_START;
         UFC_START:
            if (bit_end)
               next_state = UFC_DATA;
         UFC_DATA:
            if (bit_end && bit_idx == `UFC_LAST_BIT)
               next_state = UFC_STOP;
         UFC_STOP:
            if (bit_end)
               next_state = UFC_IDLE;
         default:
            next_state = UFC_IDLE;
      endcase
   end
   // state register
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         state <= UFC_IDLE;
      else
         state <= next_state;
   end
   // bit timing and shift register
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         bit_cnt <= '0;
         bit_idx <= '0;
         shift <= '0;
      end
      else if (state == UFC_IDLE)
      begin
         bit_cnt <= '0;
         bit_idx <= '0;
         if (pending.valid && may_start)
            shift <= pending.data;
      end
      else if (bit_end)
      begin
         bit_cnt <= '0;
         if (state == UFC_DATA)
         begin
            bit_idx <= bit_idx + 1'b1;
            shift <= shift >> 1;
         end
      end
      else
         bit_cnt <= bit_cnt + 1'b1;
   end
   // line level
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         serial_out <= `UFC_IDLE_LEVEL;
      else
         case (next_state)
            UFC_START: serial_out <= `UFC_START_LEVEL;
            UFC_DATA: serial_out <= (state == UFC_DATA && !bit_end) ?
                                    shift[0] :
                                    ((state == UFC_DATA) ?
                                    shift[1] : shift[0]);
            UFC_STOP: serial_out <= `UFC_STOP_LEVEL;
            default: serial_out <= `UFC_IDLE_LEVEL;
         endcase
   end
   assign tx_busy = (state != UFC_IDLE) || pending.valid;
   // =====================================================================
   // receive side: data register with unread flag, load beats read
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         rx_out <= '0;
      else if (rx_in.valid)
         rx_out <= rx_in;
      else if (rx_read)
         rx_out.valid <= 1'b0;
   end

   // ready-to-receive from the unread flag
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         rtr_out <= 1'b0;
         rtr_oe <= 1'b0;
      end
      else
      begin
         rtr_out <= flow_en && !rx_out.valid && !rx_in.valid;
         rtr_oe <= flow_en;
      end
   end
endmodule // ufc_port

// =====================================================================
// top: standard port and fast port side by side
module ufc_flow
   import ufc_pkg::*;
#(
   parameter int UART_BIT_CYCLES = `UFC_BIT_CYCLES,
   parameter int FAST_BIT_CYCLES = `UFC_BIT_CYCLES,
   parameter int DEPTH = `UFC_FIFO_DEPTH
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic uart_flow_en,
   input wire ufc_char_s uart_tx_in,
   output logic uart_tx_ready,
   input wire logic uart_clear_to_send_in,
   output logic uart_serial_out,
   output logic uart_tx_busy,
   input wire ufc_char_s uart_rx_in,
   input wire logic uart_rx_read,
   output ufc_char_s uart_rx_out,
   output logic uart_ready_to_receive_out,
   output logic uart_ready_to_receive_oe,
   input wire logic fast_flow_en,
   input wire ufc_char_s fast_tx_in,
   output logic fast_tx_ready,
   input wire logic fast_uart_clear_to_send_in,
   output logic fast_uart_serial_out,
   output logic fast_tx_busy,
   input wire ufc_char_s fast_rx_in,
   input wire logic fast_rx_read,
   output ufc_char_s fast_rx_out,
   output logic fast_uart_ready_to_receive_out,
   output logic fast_uart_ready_to_receive_oe
);
   // standard port
   ufc_port #(
      .BIT_CYCLES(UART_BIT_CYCLES),
      .DEPTH(DEPTH)
   ) u_uart (
      .clk(clk),
      .rst(rst),
      .flow_en(uart_flow_en),
      .tx_in(uart_tx_in),
      .tx_ready(uart_tx_ready),
      .cts_in(uart_clear_to_send_in),
      .serial_out(uart_serial_out),
      .tx_busy(uart_tx_busy),
      .rx_in(uart_rx_in),
      .rx_read(uart_rx_read),
      .rx_out(uart_rx_out),
      .rtr_out(uart_ready_to_receive_out),
      .rtr_oe(uart_ready_to_receive_oe)
   );

   // fast port, same logic with its own pair
   ufc_port #(
      .BIT_CYCLES(FAST_BIT_CYCLES),
      .DEPTH(DEPTH)
   ) u_fast (
      .clk(clk),
      .rst(rst),
      .flow_en(fast_flow_en),
      .tx_in(fast_tx_in),
      .tx_ready(fast_tx_ready),
      .cts_in(fast_uart_clear_to_send_in),
      .serial_out(fast_uart_serial_out),
      .tx_busy(fast_tx_busy),
      .rx_in(fast_rx_in),
      .rx_read(fast_rx_read),
      .rx_out(fast_rx_out),
      .rtr_out(fast_uart_ready_to_receive_out),
      .rtr_oe(fast_uart_ready_to_receive_oe)
   );
endmodule // ufc_flow

// ---- hw/ufc_defines.svh ----
// constants for the serial port flow-control block
`ifndef UFC_DEFINES_SVH
`define UFC_DEFINES_SVH
`define UFC_DATA_W 8
`define UFC_FIFO_DEPTH 16
`define UFC_BIT_CYCLES 16
`define UFC_LAST_BIT 3'h7
`define UFC_IDLE_LEVEL 1'b1
`define UFC_START_LEVEL 1'b0
`define UFC_STOP_LEVEL 1'b1
`endif

// ---- hw/ufc_pkg.sv ----
// types shared by the serial port flow-control block
package ufc_pkg;
   typedef logic [7:0] ufc_char_t;
   // one character with its valid mark
   typedef struct packed {
      logic valid;
      ufc_char_t data;
   } ufc_char_s;
   typedef enum logic [1:0] {
      UFC_IDLE = 2'b00,
      UFC_START = 2'b01,
      UFC_DATA = 2'b10,
      UFC_STOP = 2'b11
   } ufc_tx_state_e;
endpackage

// ---- verification/ufc_flow_assertions.sv ----
// port checks for the flow-control block
`timescale 1ns/1ps
// =========
// checker
module ufc_flow_assertions
   import ufc_pkg::*;
#(
   parameter int UART_BIT_CYCLES = 16
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic uart_flow_en,
   input wire logic uart_clear_to_send_in,
   input wire logic uart_serial_out,
   input wire logic uart_tx_busy,
   input wire ufc_char_s uart_rx_in,
   input wire ufc_char_s uart_rx_out,
   input wire logic uart_ready_to_receive_out,
   input wire logic uart_ready_to_receive_oe,
   input wire ufc_char_s fast_rx_out,
   input wire logic fast_uart_ready_to_receive_out
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   logic prev;
   int frm;
   wire fstart = prev && !uart_serial_out && frm == 0;
   // frame window counter, started at each start bit
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         prev <= 1'b1;
         frm <= 0;
      end
      else
      begin
         prev <= uart_serial_out;
         if (fstart)
            frm <= 10 * UART_BIT_CYCLES - 1;
         else if (frm != 0)
            frm <= frm - 1;
      end
   end
   sequence s_load;
      uart_rx_in.valid ##1 uart_rx_out.valid;
   endsequence
   rtr_off_a: assert property (
      !$past(uart_flow_en) |-> !uart_ready_to_receive_out)
      else $error("rtr driven while flow control off");
   oe_follow_a: assert property (
      !$past(rst) |-> uart_ready_to_receive_oe == $past(uart_flow_en))
      else $error("rtr enable does not follow flow control");
   cts_gate_a: assert property (
      fstart && $past(uart_flow_en) |->
      $past(uart_clear_to_send_in, 2) || $past(uart_clear_to_send_in, 3))
      else $error("frame started without clear to send");
   frame_busy_a: assert property (
      frm != 0 |-> uart_tx_busy)
      else $error("frame cut short");
   rtr_busy_a: assert property (
      uart_rx_out.valid |-> !uart_ready_to_receive_out)
      else $error("rtr high with unread char");
   rtr_free_a: assert property (
      uart_flow_en && !uart_rx_out.valid && !uart_rx_in.valid
      |=> uart_ready_to_receive_out)
      else $error("rtr low with empty register");
   load_data_a: assert property (
      s_load |-> uart_rx_out.data == $past(uart_rx_in.data))
      else $error("received char not held");
   fast_busy_a: assert property (
      fast_rx_out.valid |-> !fast_uart_ready_to_receive_out)
      else $error("fast rtr high with unread char");
endmodule // ufc_flow_assertions

bind ufc_flow ufc_flow_assertions #(.UART_BIT_CYCLES(UART_BIT_CYCLES))
   u_chk (
   .clk(clk),
   .rst(rst),
   .uart_flow_en(uart_flow_en),
   .uart_clear_to_send_in(uart_clear_to_send_in),
   .uart_serial_out(uart_serial_out),
   .uart_tx_busy(uart_tx_busy),
   .uart_rx_in(uart_rx_in),
   .uart_rx_out(uart_rx_out),
   .uart_ready_to_receive_out(uart_ready_to_receive_out),
   .uart_ready_to_receive_oe(uart_ready_to_receive_oe),
   .fast_rx_out(fast_rx_out),
   .fast_uart_ready_to_receive_out(fast_uart_ready_to_receive_out)
);

// ---- verification/ufc_peer.sv ----
// far-side serial device: paces the sender and decodes its frames
`timescale 1ns/1ps
// =========
// peer
module ufc_peer #(parameter int BC = 4)
(
   input wire logic clk,
   input wire logic hold,
   input wire logic serial_in,
   output logic cts,
   output logic [7:0] rx_byte,
   output int rx_n
);
   // clear to send follows the hold request, changed after an edge
   initial cts = 1'b0;
   always @(posedge clk) cts <= !hold;
   // sample each bit in its middle, lsb first
   initial
   begin
      rx_n = 0;
      rx_byte = 8'h00;
      forever
      begin
         @(negedge serial_in);
         repeat (BC / 2) @(posedge clk);
         for (int i = 0; i < 8; i++)
         begin
            repeat (BC) @(posedge clk);
            rx_byte[i] = serial_in;
         end
         repeat (BC) @(posedge clk);
         rx_n++;
      end
   end
endmodule // ufc_peer

// ---- verification/tb.sv ----
// self-checking bench for the flow-control block
`timescale 1ns/1ps
`define CHK(nm, e, g) \
   begin \
      cmp_count++; \
      if ((g) !== (e)) \
      begin \
         failures++; \
         $display("mismatch %s exp %h got %h", nm, e, g); \
      end \
   end
// =========
// bench
module tb;
   import ufc_pkg::*;
   localparam int BC = 4;
   logic clk, rst;
   logic [1:0] en, hold, rd, rdy, cts, so, bsy, rtr, oe;
   ufc_char_s tx[2], rx[2], ro[2];
   logic [7:0] b[2];
   int n[2];
   int failures, cmp_count, k;
   int cyc = 0;
   ufc_flow #(.UART_BIT_CYCLES(BC), .FAST_BIT_CYCLES(BC)) u_dut (
      .clk(clk), .rst(rst), .uart_flow_en(en[0]), .uart_tx_in(tx[0]),
      .uart_tx_ready(rdy[0]), .uart_clear_to_send_in(cts[0]),
      .uart_serial_out(so[0]), .uart_tx_busy(bsy[0]), .uart_rx_in(rx[0]),
      .uart_rx_read(rd[0]), .uart_rx_out(ro[0]),
      .uart_ready_to_receive_out(rtr[0]), .uart_ready_to_receive_oe(oe[0]),
      .fast_flow_en(en[1]), .fast_tx_in(tx[1]), .fast_tx_ready(rdy[1]),
      .fast_uart_clear_to_send_in(cts[1]), .fast_uart_serial_out(so[1]),
      .fast_tx_busy(bsy[1]), .fast_rx_in(rx[1]), .fast_rx_read(rd[1]),
      .fast_rx_out(ro[1]), .fast_uart_ready_to_receive_out(rtr[1]),
      .fast_uart_ready_to_receive_oe(oe[1]));
   ufc_peer #(.BC(BC)) u_p0 (.clk(clk), .hold(hold[0]), .serial_in(so[0]),
      .cts(cts[0]), .rx_byte(b[0]), .rx_n(n[0]));
   ufc_peer #(.BC(BC)) u_p1 (.clk(clk), .hold(hold[1]), .serial_in(so[1]),
      .cts(cts[1]), .rx_byte(b[1]), .rx_n(n[1]));
   task automatic push(input int p, input logic [7:0] d);
      @(negedge clk);
      tx[p] = {1'b1, d};
      @(negedge clk);
      tx[p] = '0;
   endtask
   task automatic wait_n(input int p, input int t);
      for (int i = 0; i < 1000 && n[p] < t; i++) @(negedge clk);
      `CHK("frames", t, n[p])
   endtask
   task automatic t_gate(input int p);
      int n0;
      n0 = n[p];
      hold[p] = 1'b1;
      repeat (4) @(negedge clk);
      push(p, 8'ha5);
      repeat (100) @(negedge clk);
      `CHK("held", n0, n[p])
      `CHK("busy", 1'b1, bsy[p])
      `CHK("tx ready", 1'b1, rdy[p])
      hold[p] = 1'b0;
      wait_n(p, n0 + 1);
      `CHK("byte", 8'ha5, b[p])
      $display("test gate %0d done", p);
   endtask
   task automatic t_mid;
      int n0;
      n0 = n[0];
      push(0, 8'h3c);
      for (int i = 0; i < 50 && so[0]; i++) @(negedge clk);
      `CHK("start bit", 1'b0, so[0])
      hold[0] = 1'b1;
      wait_n(0, n0 + 1);
      `CHK("mid byte", 8'h3c, b[0])
      hold[0] = 1'b0;
      $display("test mid done");
   endtask
   task automatic t_rx(input int p);
      @(negedge clk);
      rx[p] = {1'b1, 8'h5a};
      @(negedge clk);
      rx[p] = '0;
      `CHK("rtr low", 1'b0, rtr[p])
      `CHK("rx data", 9'h15a, ro[p])
      rd[p] = 1'b1;
      @(negedge clk);
      rd[p] = 1'b0;
      @(negedge clk);
      `CHK("rtr high", 1'b1, rtr[p])
      `CHK("rtr oe", 1'b1, oe[p])
      $display("test rx %0d done", p);
   endtask
   task automatic t_fill;
      int n0;
      n0 = n[0];
      k = 0;
      hold[0] = 1'b1;
      for (int i = 0; i < 20; i++)
      begin
         @(negedge clk);
         tx[0] = {1'b1, 8'(i)};
         if (rdy[0]) k++;
      end
      @(negedge clk);
      tx[0] = '0;
      `CHK("accepted", 17, k)
      hold[0] = 1'b0;
      wait_n(0, n0 + 17);
      `CHK("last byte", 8'h10, b[0])
      $display("test fill done");
   endtask
   task automatic t_off;
      int n0;
      n0 = n[0];
      en[0] = 1'b0;
      hold[0] = 1'b1;
      repeat (2) @(negedge clk);
      `CHK("rtr off", 1'b0, rtr[0])
      `CHK("oe off", 1'b0, oe[0])
      push(0, 8'h96);
      wait_n(0, n0 + 1);
      `CHK("cts ignored", 8'h96, b[0])
      hold[0] = 1'b0;
      en[0] = 1'b1;
      repeat (2) @(negedge clk);
      `CHK("oe on", 1'b1, oe[0])
      $display("test off done");
   endtask
   task automatic close_out;
      $display("counts: %0d compares, %0d mismatches", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // clock
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // hang guard
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         failures++;
         close_out;
      end
   end
   // main sequence
   initial
   begin
      rst = 1'b1;
      {en, hold, rd} = 6'h30;
      {failures, cmp_count} = 0;
      {tx[0], tx[1], rx[0], rx[1]} = '0;
      repeat (12) @(negedge clk);
      `CHK("idle line", 2'b11, so)
      `CHK("rtr reset", 2'b00, rtr)
      rst = 1'b0;
      t_gate(0);
      t_gate(1);
      t_mid;
      t_rx(0);
      t_rx(1);
      t_fill;
      t_off;
      close_out;
   end
endmodule // tb
